// file: logic/ssq_pkg.sv
/*
  constants, types and register map of the synchronous serial port master.
  assumes a 40 MHz system clock and a classic Wishbone register bus.
*/
package ssq_pkg;
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned SCLK_HZ    = 5_000_000;
  localparam int unsigned HALF_CYC   = CLK_HZ / (2 * SCLK_HZ);
  localparam logic [2:0]  PH_LEAD    = 3'(HALF_CYC - 1);
  localparam logic [2:0]  PH_SAMP    = 3'(HALF_CYC);
  localparam logic [2:0]  PH_LAST    = 3'(2 * HALF_CYC - 1);
  localparam logic [2:0]  DLY_MAX    = 3'(HALF_CYC - 1);

  localparam logic [7:0]  A_CTRL0    = 8'h00;
  localparam logic [7:0]  A_CTRL1    = 8'h04;
  localparam logic [7:0]  A_ENABLE   = 8'h08;
  localparam logic [7:0]  A_TXTHR    = 8'h0C;
  localparam logic [7:0]  A_RXTHR    = 8'h10;
  localparam logic [7:0]  A_MASK     = 8'h14;
  localparam logic [7:0]  A_RAWSTAT  = 8'h18;
  localparam logic [7:0]  A_STATUS   = 8'h20;
  localparam logic [7:0]  A_TXOCLR   = 8'h24;
  localparam logic [7:0]  A_RXOCLR   = 8'h28;
  localparam logic [7:0]  A_RXUCLR   = 8'h2C;
  localparam logic [7:0]  A_MSTCLR   = 8'h30;
  localparam logic [7:0]  A_SDLY     = 8'h34;
  localparam logic [7:0]  A_DATA     = 8'h60;

  localparam int unsigned FMT_LSB    = 4;
  localparam int unsigned CPOL_BIT   = 6;
  localparam int unsigned MODE_LSB   = 8;
  localparam int unsigned DFS_LSB    = 16;
  localparam logic [4:0]  DFS_RST    = 5'h07;

  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [4:0]  FIFO_FULL  = 5'h10;

  localparam int unsigned IRQ_TXE    = 0;
  localparam int unsigned IRQ_TXO    = 1;
  localparam int unsigned IRQ_RXF    = 2;
  localparam int unsigned IRQ_RXO    = 3;
  localparam int unsigned IRQ_RXU    = 4;
  localparam int unsigned IRQ_MST    = 5;
  localparam int unsigned IRQ_W      = 6;

  typedef enum logic [1:0] {
    SSQ_TX_RX   = 2'h0,
    SSQ_TX_ONLY = 2'h1,
    SSQ_RX_ONLY = 2'h2,
    SSQ_EE_READ = 2'h3
  } ssq_mode_t;

  typedef enum logic [1:0] {
    SSQ_FMT_SPI = 2'h0,
    SSQ_FMT_SSP = 2'h1,
    SSQ_FMT_MW  = 2'h2,
    SSQ_FMT_RSV = 2'h3
  } ssq_fmt_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} ssq_state_t;

  typedef struct packed {
    logic [4:0] dfs;
    ssq_mode_t  mode;
    logic       cpol;
    ssq_fmt_t   fmt;
  } ssq_ctrl_t;
endpackage

// file: logic/ssq_top.sv
/*
  synchronous serial port master: Wishbone register slave, 16x32 transmit
  and receive FIFOs, shift engine with four transfer modes, rx sample delay
  and level interrupts. assumes rxd_i and ss_in_n_i are asynchronous pins.
*/
// Implementation choices: the placing of the registers and the Wishbone slave port.
// Summary of operation
// - frame size from five-bit wide field
// - legacy four-bit size field writes ignored
// - FIFOs and data register 32 bits
// - combined interrupt ORs masked sources
// - interrupts level sensitive, active high
// - tx empty while level at/below threshold
// - write to full tx: drop, flag overflow
// - rx full while level at/above threshold+1
// - frame into full rx: drop, flag
// - read of empty rx: zero, flag underflow
// - foreign select sets contention flag while enabled
// - mode field, no duplex change, microwire ignores
// - mode 00 sends and stores frames
// - mode 01 sends, never stores
// - mode 10 constant output, stores frames
// - mode 11 sends opcode/address, ignores input
// - then receive frame count plus one
// - no EEPROM read mode in SSP format
// - disabled: no transfers, clock inactive
// - programmable rx sample delay, up to three cycles
// - disable or reset empties both FIFOs
// - each FIFO holds 16 frames
`timescale 1ns/1ps
module ssq_top (
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_i,     // sync reset, high
  input  wire logic        wb_cyc_i,  // bus cycle
  input  wire logic        wb_stb_i,  // bus strobe
  input  wire logic        wb_we_i,   // write enable
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte lanes
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic      [31:0] wb_dat_o,  // read data
  output logic             wb_ack_o,  // acknowledge
  output logic             sclk_o,    // bit clock
  output logic             txd_o,     // serial out
  output logic             ss_n_o,    // slave select, low
  input  wire logic        rxd_i,     // serial in
  input  wire logic        ss_in_n_i, // foreign select, low
  output logic             irq_o,     // combined interrupt
  output logic      [5:0]  irq_vec_o  // masked sources
);
  logic                  ack_q;
  logic [31:0]           rdat_q;
  ssq_pkg::ssq_ctrl_t    ctrl_q;
  logic [15:0]           ndf_q;
  logic                  en_q;
  logic [3:0]            txthr_q;
  logic [3:0]            rxthr_q;
  logic [5:0]            mask_q;
  logic [7:0]            sdly_q;
  logic                  txo_q;
  logic                  rxo_q;
  logic                  rxu_q;
  logic                  mst_q;
  logic                  irq_q;
  logic [5:0]            irqv_q;
  logic [31:0]           txm [ssq_pkg::FIFO_DEPTH];
  logic [31:0]           rxm [ssq_pkg::FIFO_DEPTH];
  logic [3:0]            txw_q;
  logic [3:0]            txr_q;
  logic [4:0]            txc_q;
  logic [3:0]            rxw_q;
  logic [3:0]            rxr_q;
  logic [4:0]            rxc_q;
  ssq_pkg::ssq_state_t   st_q;
  logic [2:0]            ph_q;
  logic [4:0]            bit_q;
  logic [31:0]           tsr_q;
  logic [31:0]           rsr_q;
  logic                  rxph_q;
  logic [15:0]           rcnt_q;
  logic                  sclk_q;
  logic                  txd_q;
  logic                  ss_n_q;
  logic                  rxd_m_q;
  logic                  rxd_s_q;
  logic                  ssi_m_q;
  logic                  ssi_s_q;

  // bus decode; side effects happen on the edge that raises ack
  wire        req       = wb_cyc_i & wb_stb_i & ~ack_q;
  wire        wr        = req & wb_we_i;
  wire        rd        = req & ~wb_we_i;
  wire [31:0] wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire        h_ctrl0   = wb_adr_i == ssq_pkg::A_CTRL0;
  wire        h_ctrl1   = wb_adr_i == ssq_pkg::A_CTRL1;
  wire        h_en      = wb_adr_i == ssq_pkg::A_ENABLE;
  wire        h_txthr   = wb_adr_i == ssq_pkg::A_TXTHR;
  wire        h_rxthr   = wb_adr_i == ssq_pkg::A_RXTHR;
  wire        h_mask    = wb_adr_i == ssq_pkg::A_MASK;
  wire        h_raw     = wb_adr_i == ssq_pkg::A_RAWSTAT;
  wire        h_stat    = wb_adr_i == ssq_pkg::A_STATUS;
  wire        h_txoc    = wb_adr_i == ssq_pkg::A_TXOCLR;
  wire        h_rxoc    = wb_adr_i == ssq_pkg::A_RXOCLR;
  wire        h_rxuc    = wb_adr_i == ssq_pkg::A_RXUCLR;
  wire        h_mstc    = wb_adr_i == ssq_pkg::A_MSTCLR;
  wire        h_sdly    = wb_adr_i == ssq_pkg::A_SDLY;
  wire        h_data    = wb_adr_i == ssq_pkg::A_DATA;

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (wb_dat_i & wmask);
  endfunction

  // legacy size bits [3:0] are never stored and read as zero
  wire [31:0] ctrl0_w   = {11'h000, ctrl_q.dfs, 6'h00, ctrl_q.mode, 1'b0, ctrl_q.cpol, ctrl_q.fmt, 4'h0};
  wire [31:0] ctrl0_n   = (ctrl0_w & ~wmask) | (wb_dat_i & wmask);

  // fifo status
  wire        tx_empty  = txc_q == 5'h00;
  wire        tx_full   = txc_q == ssq_pkg::FIFO_FULL;
  wire        rx_empty  = rxc_q == 5'h00;
  wire        rx_full   = rxc_q == ssq_pkg::FIFO_FULL;
  wire [31:0] tx_head   = txm[txr_q];
  wire [31:0] rx_head   = rxm[rxr_q];

  // effective mode; microwire, and ssp in eeprom read, fall back to mode 00
  wire        fmt_mw    = ctrl_q.fmt == ssq_pkg::SSQ_FMT_MW;
  wire        ee_ssp    = ctrl_q.fmt == ssq_pkg::SSQ_FMT_SSP && ctrl_q.mode == ssq_pkg::SSQ_EE_READ;
  wire [1:0]  mode_e    = (fmt_mw | ee_ssp) ? ssq_pkg::SSQ_TX_RX : ctrl_q.mode;
  wire        m_txonly  = mode_e == ssq_pkg::SSQ_TX_ONLY;
  wire        m_rxonly  = mode_e == ssq_pkg::SSQ_RX_ONLY;
  wire        m_ee      = mode_e == ssq_pkg::SSQ_EE_READ;
  wire        rx_phase  = m_rxonly | (m_ee & rxph_q);
  wire        store     = ~m_txonly & ~(m_ee & ~rxph_q);

  // engine events
  wire        shifting  = st_q == ssq_pkg::ST_SHIFT;
  wire        start     = ~shifting & en_q & ~tx_empty;
  wire [2:0]  dly_e     = (sdly_q > {5'h00, ssq_pkg::DLY_MAX}) ? ssq_pkg::DLY_MAX : sdly_q[2:0];
  wire        samp      = shifting & (ph_q == ssq_pkg::PH_SAMP + dly_e);
  wire        bit_end   = shifting & (ph_q == ssq_pkg::PH_LAST);
  wire        f_done    = bit_end & (bit_q == ctrl_q.dfs);
  wire        ee_turn   = m_ee & ~rxph_q & tx_empty;
  wire        cont      = rx_phase ? (rcnt_q != ndf_q) : (~tx_empty | ee_turn);
  wire        more_pop  = f_done & ~rx_phase & ~tx_empty;
  wire        tx_pop    = start | more_pop;
  wire [4:0]  sh        = 5'h1F - ctrl_q.dfs;
  wire [31:0] lenmask   = 32'hFFFF_FFFF >> sh;
  wire [31:0] rsr_n     = samp ? {rsr_q[30:0], rxd_s_q} : rsr_q;
  wire [31:0] tsr_load  = (m_rxonly | ee_turn | ~tx_pop) ? 32'h0000_0000 : (tx_head << sh);

  // fifo pushes and pops
  wire        tx_wr     = wr & h_data & en_q;
  wire        tx_push   = tx_wr & ~tx_full;
  wire        rx_load   = f_done & store;
  wire        rx_push   = rx_load & ~rx_full & en_q;
  wire        rx_rd     = rd & h_data;
  wire        rx_pop    = rx_rd & ~rx_empty;

  wire        txo_set   = tx_wr & tx_full;
  wire        rxo_set   = rx_load & rx_full;
  wire        rxu_set   = rx_rd & rx_empty;
  wire        mst_set   = en_q & ~ssi_s_q;
  wire [5:0]  raw;
  assign raw[ssq_pkg::IRQ_TXE] = txc_q <= {1'b0, txthr_q};
  assign raw[ssq_pkg::IRQ_TXO] = txo_q;
  assign raw[ssq_pkg::IRQ_RXF] = rxc_q >= ({1'b0, rxthr_q} + 5'h01);
  assign raw[ssq_pkg::IRQ_RXO] = rxo_q;
  assign raw[ssq_pkg::IRQ_RXU] = rxu_q;
  assign raw[ssq_pkg::IRQ_MST] = mst_q;

  // read mux; unmapped addresses read zero
  wire [31:0] stat_w    = {19'h00000, rxc_q, 2'h0, txc_q, shifting};
  wire [31:0] rdata     = h_ctrl0 ? ctrl0_w :
                          h_ctrl1 ? {16'h0000, ndf_q} :
                          h_en    ? {31'h0, en_q} :
                          h_txthr ? {28'h0, txthr_q} :
                          h_rxthr ? {28'h0, rxthr_q} :
                          h_mask  ? {26'h0, mask_q} :
                          h_raw   ? {26'h0, raw} :
                          h_stat  ? stat_w :
                          h_txoc  ? {31'h0, txo_q} :
                          h_rxoc  ? {31'h0, rxo_q} :
                          h_rxuc  ? {31'h0, rxu_q} :
                          h_mstc  ? {31'h0, mst_q} :
                          h_sdly  ? {24'h0, sdly_q} :
                          (h_data & ~rx_empty) ? rx_head : 32'h0000_0000;

  // empty read answers zero through rdata
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q  <= req;
      rdat_q <= rd ? rdata : 32'h0000_0000;
    end
  end

  // wide frame size taken, legacy bits dropped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q  <= '{dfs: ssq_pkg::DFS_RST, mode: ssq_pkg::SSQ_TX_RX, cpol: 1'b0, fmt: ssq_pkg::SSQ_FMT_SPI};
      ndf_q   <= 16'h0000;
      en_q    <= 1'b0;
      txthr_q <= 4'h0;
      rxthr_q <= 4'h0;
      mask_q  <= 6'h00;
      sdly_q  <= 8'h00;
    end
    else if (wr)
    begin
      if (h_ctrl0)
      begin
        ctrl_q.dfs  <= ctrl0_n[ssq_pkg::DFS_LSB +: 5];
        ctrl_q.mode <= ssq_pkg::ssq_mode_t'(ctrl0_n[ssq_pkg::MODE_LSB +: 2]);
        ctrl_q.cpol <= ctrl0_n[ssq_pkg::CPOL_BIT];
        ctrl_q.fmt  <= ssq_pkg::ssq_fmt_t'(ctrl0_n[ssq_pkg::FMT_LSB +: 2]);
      end
      if (h_ctrl1)
        ndf_q <= 16'(merge({16'h0000, ndf_q}));
      if (h_en)
        en_q <= 1'(merge({31'h0, en_q}));
      if (h_txthr)
        txthr_q <= 4'(merge({28'h0, txthr_q}));
      if (h_rxthr)
        rxthr_q <= 4'(merge({28'h0, rxthr_q}));
      if (h_mask)
        mask_q <= 6'(merge({26'h0, mask_q}));
      // delay may change at run time
      if (h_sdly)
        sdly_q <= 8'(merge({24'h0, sdly_q}));
    end
  end

  // each clear read touches its own flag only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txo_q <= 1'b0;
      rxo_q <= 1'b0;
      rxu_q <= 1'b0;
      mst_q <= 1'b0;
    end
    else
    begin
      txo_q <= (txo_q & ~(rd & h_txoc)) | txo_set;
      rxo_q <= (rxo_q & ~(rd & h_rxoc)) | rxo_set;
      rxu_q <= (rxu_q & ~(rd & h_rxuc)) | rxu_set;
      mst_q <= (mst_q & ~(rd & h_mstc)) | mst_set;
    end
  end

  // combined OR of masked sources, level, high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_q  <= 1'b0;
      irqv_q <= 6'h00;
    end
    else
    begin
      irq_q  <= |(raw & mask_q);
      irqv_q <= raw & mask_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (tx_push)
      txm[txw_q] <= wb_dat_i;
    if (rx_push)
      rxm[rxw_q] <= rsr_n & lenmask;
  end

  // disable or reset empties both fifos
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_q)
    begin
      txw_q <= 4'h0;
      txr_q <= 4'h0;
      txc_q <= 5'h00;
      rxw_q <= 4'h0;
      rxr_q <= 4'h0;
      rxc_q <= 5'h00;
    end
    else
    begin
      txw_q <= txw_q + {3'h0, tx_push};
      txr_q <= txr_q + {3'h0, tx_pop};
      txc_q <= txc_q + {4'h0, tx_push} - {4'h0, tx_pop};
      rxw_q <= rxw_q + {3'h0, rx_push};
      rxr_q <= rxr_q + {3'h0, rx_pop};
      rxc_q <= rxc_q + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // pins sampled by two flops; only the second stage is used
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxd_m_q <= 1'b0;
      rxd_s_q <= 1'b0;
      ssi_m_q <= 1'b1;
      ssi_s_q <= 1'b1;
    end
    else
    begin
      rxd_m_q <= rxd_i;
      rxd_s_q <= rxd_m_q;
      ssi_m_q <= ss_in_n_i;
      ssi_s_q <= ssi_m_q;
    end
  end

  // shift engine; aborting mid frame on disable loses that frame
  // no transfer while disabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_q)
    begin
      st_q   <= ssq_pkg::ST_IDLE;
      ph_q   <= 3'h0;
      bit_q  <= 5'h00;
      tsr_q  <= 32'h0000_0000;
      rsr_q  <= 32'h0000_0000;
      rxph_q <= 1'b0;
      rcnt_q <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        ssq_pkg::ST_IDLE:
        begin
          if (start)
          begin
            st_q   <= ssq_pkg::ST_SHIFT;
            ph_q   <= 3'h0;
            bit_q  <= 5'h00;
            tsr_q  <= tsr_load;
            rsr_q  <= 32'h0000_0000;
            rxph_q <= 1'b0;
            rcnt_q <= 16'h0000;
          end
        end
        ssq_pkg::ST_SHIFT:
        begin
          ph_q  <= ph_q + 3'h1;
          // sample point moved by delay cycles
          rsr_q <= rsr_n;
          if (bit_end)
          begin
            tsr_q <= {tsr_q[30:0], 1'b0};
            bit_q <= bit_q + 5'h01;
          end
          if (f_done)
          begin
            // clear after every frame, stored or not
            rsr_q  <= 32'h0000_0000;
            bit_q  <= 5'h00;
            tsr_q  <= tsr_load;
            // turn to receive once tx empties
            rxph_q <= rxph_q | ee_turn;
            rcnt_q <= rcnt_q + {15'h0000, rx_phase};
            if (!cont)
              st_q <= ssq_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // quiet txd in receive phases, idle clock level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_q <= 1'b0;
      txd_q  <= 1'b0;
      ss_n_q <= 1'b1;
    end
    else
    begin
      ss_n_q <= ~(shifting & en_q);
      txd_q  <= shifting & en_q & ~rx_phase & tsr_q[31];
      if (!shifting || !en_q || ph_q == ssq_pkg::PH_LAST)
        sclk_q <= ctrl_q.cpol;
      else if (ph_q == ssq_pkg::PH_LEAD)
        sclk_q <= ~ctrl_q.cpol;
    end
  end

  assign wb_ack_o  = ack_q;
  assign wb_dat_o  = rdat_q;
  assign sclk_o    = sclk_q;
  assign txd_o     = txd_q;
  assign ss_n_o    = ss_n_q;
  assign irq_o     = irq_q;
  assign irq_vec_o = irqv_q;

  sequence s_full_write;
    tx_wr && tx_full;
  endsequence

  sequence s_empty_read;
    rx_rd && rx_empty;
  endsequence

  chk_tx_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    s_full_write |=> txo_q && txc_q == $past(txc_q) - {4'h0, $past(tx_pop)})
    else $error("tx overflow not flagged or data kept");

  chk_rx_underflow: assert property (@(posedge clk_i) disable iff (rst_i)
    s_empty_read |=> wb_ack_o && wb_dat_o == 32'h0000_0000 && rxu_q)
    else $error("empty read not zero or not flagged");

  chk_irq_combined: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == |($past(raw) & $past(mask_q)))
    else $error("combined interrupt mismatch");

  chk_txe_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_vec_o[0] == ($past(mask_q[0]) && $past(txc_q) <= {1'b0, $past(txthr_q)}))
    else $error("tx empty interrupt level wrong");

  chk_rxf_level: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_vec_o[2] == ($past(mask_q[2]) && $past(rxc_q) > {1'b0, $past(rxthr_q)}))
    else $error("rx full interrupt level wrong");

  chk_disable_flush: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q |=> txc_q == 5'h00 && rxc_q == 5'h00)
    else $error("fifos not emptied while disabled");

  chk_sclk_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q ##1 !en_q |-> sclk_o == $past(ctrl_q.cpol) && ss_n_o)
    else $error("bit clock active while disabled");

  chk_txonly_nostore: assert property (@(posedge clk_i) disable iff (rst_i)
    f_done && m_txonly && !rx_rd |=> rxc_q == $past(rxc_q) && !$rose(rxo_q))
    else $error("transmit only stored a frame");

  chk_rxonly_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    shifting && m_rxonly ##1 shifting && m_rxonly |-> !txd_o)
    else $error("txd not constant in receive only");

  chk_clear_own: assert property (@(posedge clk_i) disable iff (rst_i)
    rd |=> (rxo_q || !$past(rxo_q) || $past(h_rxoc)) && (rxu_q || !$past(rxu_q) || $past(h_rxuc))
           && (mst_q || !$past(mst_q) || $past(h_mstc)))
    else $error("clear read touched another flag");

  chk_rx_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_load && rx_full && !rx_rd |=> rxo_q && rxc_q == 5'h10)
    else $error("rx overflow not flagged");
endmodule

// file: dv/ssq_slave_model.sv
/*
  serial slave model, mode 0 timing: takes txd on the sclk rise and
  shifts its reply on the sclk fall. assumes cpol 0 and the bench clock.
*/
`timescale 1ns/1ps
module ssq_slave_model #(
  parameter logic [31:0] PAT = 32'hC3A5_96E1 // reply stream
) (
  input  wire logic        clk_i,  // bench clock
  input  wire logic        sclk_i, // bit clock
  input  wire logic        ss_n_i, // select, low
  input  wire logic        txd_i,  // master data
  output logic             rxd_o,  // reply bit
  output logic      [31:0] cap_o   // last bits taken
);
  logic [31:0] pat_q;
  logic        sclk_q;
  initial
  begin
    rxd_o = 1'h0;
    cap_o = 32'h0;
    sclk_q = 1'h0;
  end
  always @(posedge clk_i)
  begin
    sclk_q <= sclk_i;
    if (ss_n_i)
    begin
      pat_q <= PAT;
      // no pull on rxd: toggle so a stale bit never looks valid
      rxd_o <= ~rxd_o;
    end
    else if (sclk_q && !sclk_i)
    begin
      pat_q <= {pat_q[30:0], pat_q[31]};
      rxd_o <= pat_q[30];
    end
    else
      rxd_o <= pat_q[31];
    if (!ss_n_i && !sclk_q && sclk_i)
      cap_o <= {cap_o[30:0], txd_i};
  end
endmodule

// file: dv/sync_serial_irq_and_transfer_modes_test.sv
/*
  self-checking bench for the serial port master: registers, modes,
  fifo flags, interrupts. assumes the slave model beside it.
*/
`timescale 1ns/1ps
module sync_serial_irq_and_transfer_modes_test;
  localparam logic [31:0] PAT = 32'hC3A5_96E1;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, ss_in_n;
  logic        wb_ack, sclk, txd, ss_n, rxd, irq;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_q, q, cap, r;
  logic [5:0]  vec;
  int unsigned n_fail, samples_checked, cyc_n, t, k, m;

  ssq_top i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_q), .wb_ack_o(wb_ack),
    .sclk_o(sclk), .txd_o(txd), .ss_n_o(ss_n), .rxd_i(rxd), .ss_in_n_i(ss_in_n), .irq_o(irq), .irq_vec_o(vec));
  ssq_slave_model #(.PAT(PAT)) i_slave (
    .clk_i(clk_i), .sclk_i(sclk), .ss_n_i(ss_n), .txd_i(txd), .rxd_o(rxd), .cap_o(cap));

  initial
  begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    do
      @(posedge clk_i);
    while (wb_ack !== 1'h1);
    q = wb_q;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge clk_i);
  endtask

  // busy shows only after start, hence the fixed settle
  task automatic wait_idle();
    repeat (8) @(posedge clk_i);
    do
      wb(1'h0, ssq_pkg::A_STATUS, 32'h0);
    while (q[5:0] !== 6'h00);
  endtask

  function automatic logic [31:0] exp_rx(input int unsigned i, input int unsigned n);
    logic [63:0] d;
    d = {PAT, PAT} << ((i * n) % 32);
    return d[63:32] >> (32 - n);
  endfunction

  task automatic xfer(input logic [1:0] fmt, input logic [1:0] md, input logic [4:0] dfs,
                      input int unsigned ntx, input int unsigned cnt);
    logic [31:0] w;
    logic [31:0] msk;
    logic [1:0]  eff;
    int unsigned nrx;
    int unsigned base;
    // microwire, or ssp with eeprom read, runs as mode 00
    eff = (fmt == 2'h2 || (fmt == 2'h1 && md == 2'h3)) ? 2'h0 : md;
    nrx = (eff == 2'h0) ? ntx : (eff == 2'h1) ? 0 : cnt + 1;
    base = (eff == 2'h3) ? ntx : 0;
    msk = 32'hFFFF_FFFF >> (31 - dfs);
    wb(1'h1, ssq_pkg::A_ENABLE, 32'h0);
    wb(1'h1, ssq_pkg::A_CTRL0, {11'h0, dfs, 6'h0, md, 2'h0, fmt, 4'h0});
    wb(1'h1, ssq_pkg::A_CTRL1, cnt);
    wb(1'h1, ssq_pkg::A_SDLY, $urandom_range(3));
    wb(1'h1, ssq_pkg::A_MASK, (eff == 2'h1) ? 32'h23 : (eff == 2'h2) ? 32'h3C : 32'h3F);
    wb(1'h1, ssq_pkg::A_ENABLE, 32'h1);
    for (int i = 0; i < ntx; i++)
    begin
      w = $urandom & msk;
      wb(1'h1, ssq_pkg::A_DATA, w);
    end
    wait_idle();
    chk("tx line", cap & msk, (eff < 2'h2) ? w : 32'h0);
    wb(1'h0, ssq_pkg::A_STATUS, 32'h0);
    chk("rx level", 32'(q[12:8]), nrx);
    for (int i = 0; i < nrx; i++)
    begin
      wb(1'h0, ssq_pkg::A_DATA, 32'h0);
      chk("rx frame", q, exp_rx(base + i, dfs + 1));
    end
  endtask

  initial
  begin
    cyc_n = 0;
    n_fail = 0;
    samples_checked = 0;
    rst_i = 1'h1;
    wb_cyc = 1'h0;
    wb_stb = 1'h0;
    wb_we = 1'h0;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    ss_in_n = 1'h1;
    void'($urandom(32'h0E9D9C5A));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, ssq_pkg::A_CTRL0, 32'h0);
    chk("ctrl0 reset", q, 32'h0007_0000);
    wb(1'h1, ssq_pkg::A_CTRL0, 32'h001F_000F);
    wb(1'h0, ssq_pkg::A_CTRL0, 32'h0);
    chk("ctrl0 legacy", q, 32'h001F_0000);
    wb(1'h0, 8'h3C, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'h1, ssq_pkg::A_MASK, 32'h3F);
    $display("test registers done");
    // eeprom read gets three address frames only
    for (k = 0; k < 6; k++)
      xfer((k == 4) ? 2'h1 : (k == 5) ? 2'h2 : 2'h0, 2'((k == 4) ? 3 : (k == 5) ? 1 : k), 5'h07,
           (k == 2) ? 1 : (k > 2) ? 3 : 1 + $urandom_range(3), $urandom_range(7));
    $display("test modes done");
    // frame sizes up to full word
    for (k = 0; k < 6; k++)
      xfer(2'h0, 2'h0, (k == 0) ? 5'h1F : 5'(3 + $urandom_range(28)), 1 + $urandom_range(2), 0);
    $display("test frame sizes done");
    // overflow on a full transmit queue
    t = $urandom_range(15);
    wb(1'h1, ssq_pkg::A_ENABLE, 32'h0);
    wb(1'h1, ssq_pkg::A_CTRL0, 32'h001F_0100);
    wb(1'h1, ssq_pkg::A_TXTHR, t);
    wb(1'h1, ssq_pkg::A_ENABLE, 32'h1);
    repeat (18) wb(1'h1, ssq_pkg::A_DATA, $urandom);
    wb(1'h0, ssq_pkg::A_STATUS, 32'h0);
    chk("tx level", 32'(q[5:1]), 32'h10);
    wb(1'h0, ssq_pkg::A_RAWSTAT, 32'h0);
    r = q;
    chk("txo txe", r & 32'h3, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    wb(1'h0, ssq_pkg::A_TXOCLR, 32'h0);
    chk("txo clear", q, 32'h1);
    wb(1'h0, ssq_pkg::A_RAWSTAT, 32'h0);
    chk("others kept", q, r & 32'h3D);
    wb(1'h1, ssq_pkg::A_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("idle pins", 32'({sclk, ss_n}), 32'h1);
    wb(1'h0, ssq_pkg::A_STATUS, 32'h0);
    chk("flushed", q & 32'h1F3F, 32'h0);
    $display("test tx flags done");
    t = $urandom_range(15);
    wb(1'h1, ssq_pkg::A_CTRL0, 32'h0007_0200);
    wb(1'h1, ssq_pkg::A_CTRL1, 32'h10);
    wb(1'h1, ssq_pkg::A_RXTHR, t);
    wb(1'h1, ssq_pkg::A_ENABLE, 32'h1);
    wb(1'h1, ssq_pkg::A_DATA, 32'h0);
    wait_idle();
    wb(1'h0, ssq_pkg::A_RXOCLR, 32'h0);
    chk("rxo", q, 32'h1);
    for (k = 16; k > 0; k--)
    begin
      wb(1'h0, ssq_pkg::A_RAWSTAT, 32'h0);
      chk("rxf", 32'(q[2]), 32'(k >= t + 1));
      wb(1'h0, ssq_pkg::A_DATA, 32'h0);
    end
    wb(1'h0, ssq_pkg::A_DATA, 32'h0);
    chk("empty read", q, 32'h0);
    chk("rxu level", 32'(vec[4]), 32'h1);
    wb(1'h0, ssq_pkg::A_RXUCLR, 32'h0);
    chk("rxu clear", q, 32'h1);
    $display("test rx flags done");
    ss_in_n <= 1'h0;
    repeat (6) @(posedge clk_i);
    ss_in_n <= 1'h1;
    m = $urandom_range(63);
    wb(1'h1, ssq_pkg::A_MASK, m);
    wb(1'h0, ssq_pkg::A_RAWSTAT, 32'h0);
    chk("mst raw", q & 32'h20, 32'h20);
    chk("vec", 32'(vec), q & m);
    chk("irq or", 32'(irq), 32'(|(q & m)));
    wb(1'h0, ssq_pkg::A_RXOCLR, 32'h0);
    chk("rxo idle", q, 32'h0);
    wb(1'h0, ssq_pkg::A_MSTCLR, 32'h0);
    chk("mst clear", q, 32'h1);
    $display("test contention done");
    tally_and_finish();
  end
endmodule
